// ### tsr_slave_rx.sv
// Function
// - own_slave_address bits 7..1 hold the 7-bit address the slave answers.
// - own_slave_address bit 0 enables answering the general call address 0x00.
// - own or general call address is acknowledged only while ack_enable is one.
// - direction bit 0 enters receive mode, direction bit 1 enters transmit mode.
// - after own address plus write, set event_flag and present a status code.
// - lost arbitration then addressed for write gives status 0x68 or 0x78.
// - ack_enable cleared mid-transfer makes the next data byte get a NACK.
// - with ack_enable zero the address is ignored; recognition resumes when set.
// - in deep sleep, with ack_enable set, the address still matches and wakes.
// - after a waking match, SCL is held low until event_flag is cleared; the code holds it for a write address only.
// - after deep sleep the data register need not hold the last bus byte.
// - status 0x60 for own address with write acknowledged.
// - status 0x68 for lost arbitration then own write address acknowledged.
// - status 0x70 for general call address acknowledged.
// - status 0x78 for lost arbitration then general call acknowledged.
// - status 0x80 for a data byte acknowledged after own write address.
// - status 0x88 for a data byte not acknowledged; then unaddressed slave.
// - leaving addressed state re-arms recognition; start_request waits for free bus.
// - writing one to event_flag clears it and lets the transfer continue.
//
// Local design decisions: the address map and the APB slave port.
module tsr_slave_rx
    import tsr_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic deep_sleep,
    input wire logic master_arb_lost,
    output logic wake_req,
    output logic slave_transmit_mode,
    output logic start_pending,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////////
    // state
    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] own;
        logic [7:0] data;
        logic [7:0] code;
        logic [1:0] presc;
        tsr_state_t fsm;
        logic [7:0] shift;
        logic [3:0] cnt;
        logic gc;
        logic arb;
        logic in_data;
        logic acked;
        logic sda_drv;
        logic scl_hold;
        logic wake;
        logic tx_dir;
        logic bus_free;
    } tsr_regs_t;

    tsr_regs_t r_r;
    tsr_regs_t r_nxt;
    logic [1:0] rst_q_r;
    logic rst_sync_n;

    tsr_line_if line ();

    tsr_line_sync u_sync (
        .ref_clk(ref_clk),
        .rst_sync_n(rst_sync_n),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .line(line)
    );

    ////////////////////////////////////////////////////////////////////////////
    // reset release
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_q_r <= 2'h0;
        end else begin
            rst_q_r <= {rst_q_r[0], 1'b1};
        end
    end
    assign rst_sync_n = rst_q_r[1];

    ////////////////////////////////////////////////////////////////////////////
    // helpers
    function automatic logic [7:0] status_code(input logic in_data, input logic gc,
                                               input logic arb, input logic acked);
        logic [7:0] c;
        c = TSR_SC_NONE;
        if (!in_data) begin
            if (gc) begin
                c = arb ? TSR_SC_ARB_GCALL : TSR_SC_GCALL;
            end else begin
                c = arb ? TSR_SC_ARB_OWN_W : TSR_SC_OWN_W;
            end
        end else if (gc) begin
            c = acked ? TSR_SC_GC_ACK : TSR_SC_GC_NACK;
        end else begin
            c = acked ? TSR_SC_DATA_ACK : TSR_SC_DATA_NACK;
        end
        return c;
    endfunction : status_code

    function automatic logic [31:0] read_mux(input tsr_regs_t r, input logic [7:0] a);
        logic [31:0] d;
        d = 32'h0;
        case (a)
            TSR_OFF_CTRL: d = {24'h0, r.ctrl};
            TSR_OFF_OWN: d = {24'h0, r.own};
            TSR_OFF_STAT: d = {24'h0, r.code[7:3], 1'b0, r.presc};
            TSR_OFF_DATA: d = {24'h0, r.data};
            default: d = 32'h0;
        endcase
        return d;
    endfunction : read_mux

    function automatic logic mapped(input logic [7:0] a);
        return (a == TSR_OFF_CTRL) || (a == TSR_OFF_OWN) ||
               (a == TSR_OFF_STAT) || (a == TSR_OFF_DATA);
    endfunction : mapped

    ////////////////////////////////////////////////////////////////////////////
    // next state
    logic wr;
    logic set_flag;
    logic addr_hit;
    logic enabled;
    logic addressed_rx;

    assign wr = psel & penable & pwrite & mapped(paddr);
    assign enabled = r_r.ctrl[TSR_B_IF_EN];
    assign addressed_rx = !r_r.tx_dir &&
                          (r_r.fsm == S_DATA || r_r.fsm == S_ACK || r_r.fsm == S_HOLD);
    // own address match or enabled general call, gated by ack_enable
    assign addr_hit = r_r.ctrl[TSR_B_ACK_EN] &&
                      ((r_r.shift[7:1] == r_r.own[7:1]) ||
                       (r_r.shift[7:1] == TSR_GCALL_ADDR && r_r.own[0]));

    always_comb begin
        r_nxt = r_r;
        set_flag = 1'b0;

        if (master_arb_lost) begin
            r_nxt.arb = 1'b1;
        end
        if (line.start_det) begin
            r_nxt.bus_free = 1'b0;
        end else if (line.stop_det) begin
            r_nxt.bus_free = 1'b1;
        end

        if (!enabled) begin
            r_nxt.fsm = S_IDLE;
            r_nxt.sda_drv = 1'b0;
            r_nxt.scl_hold = 1'b0;
            r_nxt.wake = 1'b0;
        end else if ((line.start_det || line.stop_det) && r_r.fsm != S_HOLD) begin
            if (addressed_rx) begin
                r_nxt.code = TSR_SC_STOP;
                set_flag = 1'b1;
            end
            r_nxt.fsm = line.start_det ? S_ADDR : S_IDLE;
            r_nxt.cnt = 4'h0;
            r_nxt.sda_drv = 1'b0;
            r_nxt.tx_dir = 1'b0;
            r_nxt.in_data = 1'b0;
        end else begin
            unique case (r_r.fsm)
                S_IDLE, S_PASS: begin
                end
                S_ADDR, S_DATA: begin
                    if (line.scl_rise) begin
                        r_nxt.shift = {r_r.shift[6:0], line.sda_lvl};
                        r_nxt.cnt = r_r.cnt + 4'h1;
                    end else if (line.scl_fall && r_r.cnt == TSR_BITS_PER_BYTE) begin
                        r_nxt.cnt = 4'h0;
                        if (r_r.fsm == S_ADDR) begin
                            if (addr_hit) begin
                                r_nxt.gc = (r_r.shift[7:1] == TSR_GCALL_ADDR);
                                r_nxt.tx_dir = r_r.shift[0];
                                r_nxt.in_data = 1'b0;
                                r_nxt.acked = 1'b1;
                                r_nxt.sda_drv = 1'b1;
                                r_nxt.wake = deep_sleep;
                                r_nxt.fsm = S_ACK;
                            end else begin
                                r_nxt.fsm = S_PASS;
                            end
                        end else begin
                            // ack_enable sampled now decides this byte
                            r_nxt.acked = r_r.ctrl[TSR_B_ACK_EN];
                            r_nxt.sda_drv = r_r.ctrl[TSR_B_ACK_EN];
                            r_nxt.in_data = 1'b1;
                            r_nxt.fsm = S_ACK;
                        end
                    end
                end
                S_ACK: begin
                    if (line.scl_fall) begin
                        r_nxt.sda_drv = 1'b0;
                        if (r_r.tx_dir) begin
                            r_nxt.fsm = S_PASS;
                            r_nxt.arb = 1'b0;
                            r_nxt.wake = 1'b0;
                        end else begin
                            r_nxt.code = status_code(r_r.in_data, r_r.gc, r_r.arb,
                                                     r_r.acked);
                            set_flag = 1'b1;
                            r_nxt.scl_hold = 1'b1;
                            if (r_r.in_data && !deep_sleep) begin
                                r_nxt.data = r_r.shift;
                            end
                            r_nxt.fsm = S_HOLD;
                        end
                    end
                end
                S_HOLD: begin
                    if (!r_r.ctrl[TSR_B_FLAG]) begin
                        r_nxt.scl_hold = 1'b0;
                        r_nxt.wake = 1'b0;
                        r_nxt.arb = 1'b0;
                        r_nxt.cnt = 4'h0;
                        // a refused byte drops the slave to unaddressed
                        r_nxt.fsm = (r_r.in_data && !r_r.acked) ? S_PASS : S_DATA;
                    end
                end
            endcase
        end

        // register writes
        if (wr && paddr == TSR_OFF_CTRL) begin
            r_nxt.ctrl = (r_r.ctrl & ~TSR_CTRL_WMASK) | (pwdata[7:0] & TSR_CTRL_WMASK);
            if (pwdata[TSR_B_FLAG]) begin
                r_nxt.ctrl[TSR_B_FLAG] = 1'b0;
            end
        end
        if (wr && paddr == TSR_OFF_OWN) begin
            r_nxt.own = pwdata[7:0];
        end
        if (wr && paddr == TSR_OFF_STAT) begin
            r_nxt.presc = pwdata[1:0];
        end
        if (wr && paddr == TSR_OFF_DATA) begin
            r_nxt.data = pwdata[7:0];
            if (!r_r.ctrl[TSR_B_FLAG]) begin
                r_nxt.ctrl[TSR_B_WCOL] = 1'b1;
            end
        end
        // hardware set wins over a clear in the same cycle
        if (set_flag) begin
            r_nxt.ctrl[TSR_B_FLAG] = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            r_r <= '{ctrl: TSR_RST_CTRL, own: TSR_RST_OWN, data: TSR_RST_DATA,
                     code: TSR_SC_NONE, presc: TSR_RST_PRESC, fsm: S_IDLE,
                     shift: 8'h00, cnt: 4'h0, gc: 1'b0, arb: 1'b0, in_data: 1'b0,
                     acked: 1'b0, sda_drv: 1'b0, scl_hold: 1'b0, wake: 1'b0,
                     tx_dir: 1'b0, bus_free: 1'b1};
        end else begin
            r_r <= r_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    assign prdata = read_mux(r_r, paddr);
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped(paddr);

    assign scl_o = 1'b0;
    assign scl_oe = r_r.scl_hold;
    assign sda_o = 1'b0;
    assign sda_oe = r_r.sda_drv;
    assign wake_req = r_r.wake;
    assign slave_transmit_mode = r_r.tx_dir && r_r.fsm != S_IDLE;
    assign start_pending = enabled & r_r.ctrl[TSR_B_START_REQ] & r_r.bus_free;
    assign irq = r_r.ctrl[TSR_B_FLAG] & r_r.ctrl[TSR_B_IRQ_EN];

endmodule : tsr_slave_rx

// ### tsr_pkg.sv
package tsr_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register map (byte addresses)
    localparam logic [7:0] TSR_OFF_CTRL = 8'h00;
    localparam logic [7:0] TSR_OFF_OWN = 8'h04;
    localparam logic [7:0] TSR_OFF_STAT = 8'h08;
    localparam logic [7:0] TSR_OFF_DATA = 8'h0c;

    ////////////////////////////////////////////////////////////////////////////
    // bus_control field positions
    localparam int TSR_B_FLAG = 7;
    localparam int TSR_B_ACK_EN = 6;
    localparam int TSR_B_START_REQ = 5;
    localparam int TSR_B_STOP_REQ = 4;
    localparam int TSR_B_WCOL = 3;
    localparam int TSR_B_IF_EN = 2;
    localparam int TSR_B_IRQ_EN = 0;
    localparam logic [7:0] TSR_CTRL_WMASK = 8'h75;

    ////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [7:0] TSR_RST_CTRL = 8'h00;
    localparam logic [7:0] TSR_RST_OWN = 8'hfe;
    localparam logic [7:0] TSR_RST_DATA = 8'hff;
    localparam logic [1:0] TSR_RST_PRESC = 2'h0;

    ////////////////////////////////////////////////////////////////////////////
    // status codes
    localparam logic [7:0] TSR_SC_OWN_W = 8'h60;
    localparam logic [7:0] TSR_SC_ARB_OWN_W = 8'h68;
    localparam logic [7:0] TSR_SC_GCALL = 8'h70;
    localparam logic [7:0] TSR_SC_ARB_GCALL = 8'h78;
    localparam logic [7:0] TSR_SC_DATA_ACK = 8'h80;
    localparam logic [7:0] TSR_SC_DATA_NACK = 8'h88;
    localparam logic [7:0] TSR_SC_GC_ACK = 8'h90;
    localparam logic [7:0] TSR_SC_GC_NACK = 8'h98;
    localparam logic [7:0] TSR_SC_STOP = 8'ha0;
    localparam logic [7:0] TSR_SC_NONE = 8'hf8;
    localparam logic [6:0] TSR_GCALL_ADDR = 7'h00;
    localparam logic [3:0] TSR_BITS_PER_BYTE = 4'h8;

    typedef enum logic [2:0] {
        S_IDLE,
        S_ADDR,
        S_ACK,
        S_HOLD,
        S_DATA,
        S_PASS
    } tsr_state_t;

endpackage : tsr_pkg

// ### tsr_line_if.sv
interface tsr_line_if;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic sda_lvl;

    modport prod (output scl_rise, scl_fall, start_det, stop_det, sda_lvl);
    modport cons (input scl_rise, scl_fall, start_det, stop_det, sda_lvl);
endinterface : tsr_line_if

// ### tsr_line_sync.sv
module tsr_line_sync
    import tsr_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_sync_n,
    input wire logic scl_i,
    input wire logic sda_i,
    tsr_line_if.prod line
);
    typedef struct packed {
        logic [1:0] scl_m;
        logic [1:0] sda_m;
        logic scl_q;
        logic sda_q;
    } tsr_sync_t;

    tsr_sync_t s_r;
    tsr_sync_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        s_nxt.scl_m = {s_r.scl_m[0], scl_i};
        s_nxt.sda_m = {s_r.sda_m[0], sda_i};
        s_nxt.scl_q = s_r.scl_m[1];
        s_nxt.sda_q = s_r.sda_m[1];
    end

    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            s_r <= '{scl_m: 2'h3, sda_m: 2'h3, scl_q: 1'b1, sda_q: 1'b1};
        end else begin
            s_r <= s_nxt;
        end
    end

    // edges compare second stage against its delayed copy only
    assign line.scl_rise = s_r.scl_m[1] & ~s_r.scl_q;
    assign line.scl_fall = ~s_r.scl_m[1] & s_r.scl_q;
    assign line.start_det = s_r.scl_m[1] & s_r.scl_q & ~s_r.sda_m[1] & s_r.sda_q;
    assign line.stop_det = s_r.scl_m[1] & s_r.scl_q & s_r.sda_m[1] & ~s_r.sda_q;
    assign line.sda_lvl = s_r.sda_m[1];

endmodule : tsr_line_sync

// ### tsr_bus_master_model.sv
module tsr_bus_master_model (
    input wire logic ref_clk,
    input wire logic scl_oe,
    input wire logic sda_oe,
    output logic scl,
    output logic sda
);
    timeunit 1ns;
    timeprecision 1ns;
    logic scl_low = 1'b0;
    logic sda_low = 1'b0;
    // wired-and lines with pull-ups
    assign scl = !(scl_low || scl_oe);
    assign sda = !(sda_low || sda_oe);
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : tick
    // release scl, wait out a stretch, then hold high
    task automatic scl_up();
        int i;
        scl_low <= 1'b0;
        for (i = 0; i < 4000 && scl !== 1'b1; i++) begin
            tick(1);
        end
        if (scl !== 1'b1) testbench.hang();
        tick(3);
    endtask : scl_up
    task automatic start();
        sda_low <= 1'b0;
        tick(4);
        scl_up();
        sda_low <= 1'b1;
        tick(4);
        scl_low <= 1'b1;
        tick(4);
    endtask : start
    task automatic stop();
        tick(1);
        sda_low <= 1'b1;
        tick(4);
        scl_up();
        sda_low <= 1'b0;
        tick(4);
    endtask : stop
    // msb first, ninth bit released for the answer
    task automatic send(input logic [7:0] b, output logic ack);
        int k;
        for (k = 7; k >= -1; k--) begin
            tick(1);
            sda_low <= (k >= 0) ? !b[k[2:0]] : 1'b0;
            tick(3);
            scl_up();
            ack = (sda === 1'b0);
            scl_low <= 1'b1;
        end
    endtask : send
endmodule : tsr_bus_master_model

// ### tsr_slave_rx_asserts.sv
module tsr_slave_rx_asserts
    import tsr_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic scl_i,
    input wire logic scl_o,
    input wire logic scl_oe,
    input wire logic sda_o,
    input wire logic sda_oe,
    input wire logic start_pending,
    input wire logic irq,
    input wire logic wake_req
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    logic acc, map, cwr, clr;
    logic clr_d_r;
    assign acc = psel && penable;
    assign map = paddr inside {TSR_OFF_CTRL, TSR_OFF_OWN, TSR_OFF_STAT, TSR_OFF_DATA};
    assign cwr = acc && pwrite && paddr == TSR_OFF_CTRL;
    assign clr = cwr && pwdata[TSR_B_FLAG];
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            clr_d_r <= 1'b0;
        end else begin
            clr_d_r <= clr;
        end
    end
    property p_pready; acc |-> pready; endproperty
    a_pready: assert property (p_pready) else $error("pready low in access");
    property p_unmapped; acc && !map |-> pslverr && prdata == 32'h0; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access");
    property p_status_mask; acc && !pwrite && paddr == TSR_OFF_STAT |-> !prdata[2]; endproperty
    a_status_mask: assert property (p_status_mask) else $error("status bit 2 set");
    property p_open_drain; !scl_o && !sda_o; endproperty
    a_open_drain: assert property (p_open_drain) else $error("line driven high");
    property p_irq_off; cwr && !pwdata[TSR_B_IRQ_EN] |=> !irq; endproperty
    a_irq_off: assert property (p_irq_off) else $error("irq while disabled");
    property p_hold; scl_oe && !clr && !clr_d_r |=> scl_oe; endproperty
    a_hold: assert property (p_hold) else $error("scl let go early");
    property p_release; clr |-> ##[1:2] !scl_oe; endproperty
    a_release: assert property (p_release) else $error("scl not let go");
    property p_sda_move; $changed(sda_oe) |-> !scl_i; endproperty
    a_sda_move: assert property (p_sda_move) else $error("sda moved while scl high");
    property p_ack_len; $rose(sda_oe) |-> sda_oe[*6]; endproperty
    a_ack_len: assert property (p_ack_len) else $error("ack too short");
    property p_start_off; cwr && !pwdata[TSR_B_START_REQ] |=> !start_pending; endproperty
    a_start_off: assert property (p_start_off) else $error("start pending stuck");
    c_irq: cover property ($rose(irq));
    c_wake: cover property ($rose(wake_req));
    c_start: cover property ($rose(start_pending));
endmodule : tsr_slave_rx_asserts
////////////////////////////////////////////////////////////////////////////////
bind tsr_slave_rx tsr_slave_rx_asserts u_chk (
    .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe), .sda_o(sda_o), .sda_oe(sda_oe),
    .start_pending(start_pending), .irq(irq), .wake_req(wake_req)
);

// ### testbench.sv
module testbench
    import tsr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] OWN_W = 8'h54;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic deep_sleep = 1'b0;
    logic master_arb_lost = 1'b0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, scl, sda, scl_oe, sda_oe, wake_req, tx_mode, start_pending, irq;
    logic err, ack;
    logic [7:0] code [4] = '{TSR_SC_OWN_W, TSR_SC_GCALL, TSR_SC_ARB_OWN_W, TSR_SC_ARB_GCALL};
    int n_mismatch = 0;
    int cmp_count = 0;
    always #25 ref_clk = ~ref_clk;
    tsr_slave_rx dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .scl_i(scl), .scl_o(), .scl_oe(scl_oe), .sda_i(sda), .sda_o(), .sda_oe(sda_oe),
        .deep_sleep(deep_sleep), .master_arb_lost(master_arb_lost), .wake_req(wake_req),
        .slave_transmit_mode(tx_mode), .start_pending(start_pending), .irq(irq)
    );
    tsr_bus_master_model m (
        .ref_clk(ref_clk), .scl_oe(scl_oe), .sda_oe(sda_oe), .scl(scl), .sda(sda)
    );
    ////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : tally_and_finish
    task automatic hang();
        n_mismatch++;
        tally_and_finish();
    endtask : hang
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int i;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge ref_clk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge ref_clk);
            if (pready === 1'b1) break;
        end
        if (i == 16) hang();
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        chk($sformatf("reg %h", a), {24'h0, e}, rd);
    endtask : rdc
    // poll the flag, then read the masked status code
    task automatic ev(input logic [7:0] e);
        int i;
        for (i = 0; i < 60; i++) begin
            apb(1'b0, TSR_OFF_CTRL, 8'h00);
            if (rd[TSR_B_FLAG] === 1'b1) break;
        end
        if (i == 60) hang();
        apb(1'b0, TSR_OFF_STAT, 8'h00);
        chk("status", {24'h0, e}, rd & 32'hf8);
    endtask : ev
    task automatic dbyte(input logic [7:0] b, input logic a, input logic [7:0] e);
        m.send(b, ack);
        chk("ack", {31'h0, a}, {31'h0, ack});
        if (e != 8'h00) ev(e);
    endtask : dbyte
    task automatic addr(input logic [7:0] b, input logic a, input logic [7:0] e);
        m.start();
        dbyte(b, a, e);
    endtask : addr
    task automatic stop_f();
        m.stop();
        ev(TSR_SC_STOP);
        wr(TSR_OFF_CTRL, 8'hc5);
    endtask : stop_f
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (90000) @(posedge ref_clk);
        hang();
    end
    initial begin
        int i;
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        rdc(TSR_OFF_CTRL, TSR_RST_CTRL);
        rdc(TSR_OFF_OWN, TSR_RST_OWN);
        rdc(TSR_OFF_STAT, TSR_SC_NONE);
        rdc(TSR_OFF_DATA, TSR_RST_DATA);
        apb(1'b0, 8'h10, 8'h00);
        chk("slverr", 32'h1, {31'h0, err});
        chk("unmapped", 32'h0, rd);
        wr(TSR_OFF_STAT, 8'h03);
        rdc(TSR_OFF_STAT, TSR_SC_NONE | 8'h03);
        wr(TSR_OFF_OWN, 8'h55);
        rdc(TSR_OFF_OWN, 8'h55);
        wr(TSR_OFF_CTRL, 8'h45);
        $display("test registers done");
        for (i = 0; i < 4; i++) begin
            master_arb_lost <= i[1];
            @(posedge ref_clk);
            master_arb_lost <= 1'b0;
            addr(i[0] ? 8'h00 : OWN_W, 1'b1, code[i]);
            chk("irq", 32'h1, {31'h0, irq});
            wr(TSR_OFF_CTRL, 8'hc5);
            stop_f();
        end
        $display("test address codes done");
        addr(OWN_W, 1'b1, TSR_SC_OWN_W);
        wr(TSR_OFF_CTRL, 8'hc5);
        dbyte(8'h5a, 1'b1, TSR_SC_DATA_ACK);
        rdc(TSR_OFF_DATA, 8'h5a);
        wr(TSR_OFF_CTRL, 8'h85);
        dbyte(8'ha3, 1'b0, TSR_SC_DATA_NACK);
        wr(TSR_OFF_CTRL, 8'h84);
        dbyte(8'h77, 1'b0, 8'h00);
        m.stop();
        addr(OWN_W, 1'b0, 8'h00);
        m.stop();
        wr(TSR_OFF_CTRL, 8'h45);
        addr(8'h56, 1'b0, 8'h00);
        m.stop();
        wr(TSR_OFF_OWN, 8'h54);
        addr(8'h00, 1'b0, 8'h00);
        m.stop();
        addr(8'h55, 1'b1, 8'h00);
        chk("tx mode", 32'h1, {31'h0, tx_mode});
        m.stop();
        $display("test data and refusal done");
        deep_sleep <= 1'b1;
        addr(OWN_W, 1'b1, TSR_SC_OWN_W);
        chk("wake", 32'h1, {31'h0, wake_req});
        chk("scl held", 32'h1, {31'h0, scl_oe});
        deep_sleep <= 1'b0;
        wr(TSR_OFF_CTRL, 8'hc5);
        repeat (2) @(posedge ref_clk);
        chk("wake", 32'h0, {31'h0, wake_req});
        stop_f();
        $display("test sleep done");
        wr(TSR_OFF_CTRL, 8'h65);
        @(posedge ref_clk);
        chk("start pending", 32'h1, {31'h0, start_pending});
        wr(TSR_OFF_DATA, 8'h12);
        rdc(TSR_OFF_CTRL, 8'h6d);
        wr(TSR_OFF_CTRL, 8'h45);
        $display("test start request done");
        tally_and_finish();
    end
endmodule : testbench
